//--- hdl/hpp_dev.sv
`timescale 1ns/1ps
module hpp_dev
  import hpp_pkg::*;
#(
  parameter logic [CSEL_W-1:0] DEV_ID = DEV_ID_DEFAULT
) (
  hpp_if.dev bus,
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] user_addr,
  output logic [DATA_W-1:0] user_rdata,
  output logic [2:0] user_mode
);
  import hpp_pkg::*;

  // one-hot access sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACT = 3'b010,
    ST_DONE = 3'b100
  } hpp_state_e;

  hpp_state_e state;
  logic [2:0] mode_s1, mode_s2;
  logic [7:0] ctl_s1, ctl_s2;
  logic [DATA_W-1:0] dat_s1, dat_s2;
  logic [ADDR_W-1:0] adr_s1, adr_s2;
  logic [CSEL_W-1:0] hi_s1, hi_s2;
  logic [2:0] um_s1, um_s2;

  logic ale_d;
  logic [ADDR_W-1:0] addr_lat;
  // register file, unknown until written
  logic [DATA_W-1:0] regs [REG_DEPTH];

  logic [3:0] wait_cnt;
  logic acc_rd;
  logic [DATA_W-1:0] rd_q;
  logic [ADDR_W-1:0] usr_s1, usr_s2;

  // direction-line styles share one decode
  function automatic logic dir_style(input logic [2:0] m);
    return (m == MODE_SYNC) || (m == MODE_DIRLINE);
  endfunction : dir_style

  // decoded from the synchronised pins
  wire cs_s = ctl_s2[0];
  wire ale_s = ctl_s2[1];
  wire rdwe_s = ctl_s2[2];
  wire wrdir_s = ctl_s2[3];
  wire dir_on = dir_style(mode_s2);
  wire selected = !cs_s && (hi_s2 == DEV_ID);
  // capture edge and request can arrive in the same sample
  wire ale_fall = ale_d && !ale_s;
  // strobe tied high makes the latch transparent
  wire [ADDR_W-1:0] eff_addr = (ale_s || ale_fall) ? adr_s2 : addr_lat;
  wire rd_req = dir_on ? (!rdwe_s && wrdir_s) : !rdwe_s;
  wire wr_req = dir_on ? (!rdwe_s && !wrdir_s) : (!wrdir_s && rdwe_s);
  wire strobe_on = dir_on ? !rdwe_s : (!rdwe_s || !wrdir_s);
  wire commit = (state == ST_ACT) && !acc_rd && (wait_cnt <= 4'h1) && selected && strobe_on;

  // link side runs on the host bus clock
  // each pin passes two flops; the strobes share one chain, the address has its own
  always_ff @(posedge bus.bus_clk or negedge rst_b) begin
    if (!rst_b) begin
      // idle pin levels, so no capture edge shows after reset
      ctl_s1 <= 8'h0d;
      ctl_s2 <= 8'h0d;
      mode_s1 <= 3'h0;
      mode_s2 <= 3'h0;
      dat_s1 <= 8'h00;
      dat_s2 <= 8'h00;
      adr_s1 <= 8'h00;
      adr_s2 <= 8'h00;
      hi_s1 <= 3'h0;
      hi_s2 <= 3'h0;
    end else if (clk_en) begin
      ctl_s1 <= {4'h0, bus.wr_dir, bus.rd_we_n, bus.addr_capture_strobe, bus.cs_n};
      ctl_s2 <= ctl_s1;
      mode_s1 <= bus.host_mode_select;
      mode_s2 <= mode_s1;
      dat_s1 <= bus.data_bus;
      dat_s2 <= dat_s1;
      adr_s1 <= bus.addr;
      adr_s2 <= adr_s1;
      hi_s1 <= bus.addr_hi;
      hi_s2 <= hi_s1;
    end
  end

  // capture on falling edge of the address strobe
  always_ff @(posedge bus.bus_clk or negedge rst_b) begin
    if (!rst_b) begin
      ale_d <= 1'b0;
      addr_lat <= 8'h00;
    end else if (clk_en) begin
      ale_d <= ale_s;
      if (ale_fall) begin
        addr_lat <= adr_s2;
      end
    end
  end

  // completion stays low until the host lets go of its strobe
  always_ff @(posedge bus.bus_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      wait_cnt <= 4'h0;
      acc_rd <= 1'b0;
      rd_q <= 8'h00;
      bus.cycle_done_n <= 1'b1;
      bus.data_dev_oe <= 1'b0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          bus.cycle_done_n <= 1'b1;
          if (selected && (rd_req || wr_req)) begin
            acc_rd <= rd_req;
            wait_cnt <= 4'(DONE_CYC);
            rd_q <= regs[eff_addr];
            bus.data_dev_oe <= rd_req;
            state <= ST_ACT;
          end
        end
        ST_ACT: begin
          // re-read so an address latched late still lands
          rd_q <= regs[eff_addr];
          if (!selected || !strobe_on) begin
            // host gave up before completion
            bus.cycle_done_n <= 1'b1;
            bus.data_dev_oe <= 1'b0;
            state <= ST_IDLE;
          end else if (wait_cnt <= 4'h1) begin
            bus.cycle_done_n <= 1'b0;
            state <= ST_DONE;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        ST_DONE: begin
          if (!strobe_on || !selected) begin
            bus.cycle_done_n <= 1'b1;
            bus.data_dev_oe <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // write commits when the wait count runs out, in the cycle that drives completion low
  always_ff @(posedge bus.bus_clk) begin
    if (clk_en && commit) begin
      regs[eff_addr] <= dat_s2;
    end
  end

  // read data reaches the pins only while data_dev_oe is high
  assign bus.data_dev = rd_q;

  // user read port on the system clock
  // the array is read across domains: valid once host writes have settled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      usr_s1 <= 8'h00;
      usr_s2 <= 8'h00;
      um_s1 <= 3'h0;
      um_s2 <= 3'h0;
      user_rdata <= 8'h00;
      user_mode <= 3'h0;
    end else if (clk_en) begin
      usr_s1 <= user_addr;
      usr_s2 <= usr_s1;
      // strap copy taken from the pins on this clock
      um_s1 <= bus.host_mode_select;
      um_s2 <= um_s1;
      user_rdata <= regs[usr_s2];
      user_mode <= um_s2;
    end
  end
endmodule : hpp_dev

//--- hdl/hpp_host.sv
`timescale 1ns/1ps
module hpp_host
  import hpp_pkg::*;
(
  hpp_if.host bus,
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [2:0] mode,
  input wire logic req,
  input wire logic req_rd,
  input wire logic [CSEL_W-1:0] req_dev,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata
);
  import hpp_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_ADDR = 5'b00010,
    H_LATCH = 5'b00100,
    H_STRB = 5'b01000,
    H_END = 5'b10000
  } hpp_hstate_e;

  hpp_hstate_e st;
  logic [3:0] div_cnt;
  logic rdy_s1, rdy_s2;
  logic rd_op;
  logic is_sync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 4'h0;
      bus.bus_clk <= 1'b0;
    end else if (clk_en) begin
      if (div_cnt == 4'(HOST_DIV - 1)) begin
        div_cnt <= 4'h0;
        bus.bus_clk <= !bus.bus_clk;
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
    end else if (clk_en) begin
      rdy_s1 <= bus.cycle_done_n;
      rdy_s2 <= rdy_s1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= H_IDLE;
      rd_op <= 1'b0;
      is_sync <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      bus.host_mode_select <= MODE_STROBE;
      bus.addr <= 8'h00;
      bus.addr_hi <= 3'h0;
      bus.cs_n <= 1'b1;
      bus.addr_capture_strobe <= 1'b0;
      bus.rd_we_n <= 1'b1;
      bus.wr_dir <= 1'b1;
      bus.data_host <= 8'h00;
      bus.data_host_oe <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      bus.host_mode_select <= mode;
      case (st)
        H_IDLE: begin
          if (req) begin
            rd_op <= req_rd;
            is_sync <= (mode != MODE_STROBE);
            busy <= 1'b1;
            bus.addr <= req_addr;
            bus.addr_hi <= req_dev;
            bus.cs_n <= 1'b0;
            bus.addr_capture_strobe <= 1'b1;
            bus.data_host <= req_wdata;
            st <= H_ADDR;
          end
        end
        H_ADDR: begin
          // leave on a bus_clk rise so the device has seen the strobe high
          if (div_cnt == 4'(HOST_DIV - 1) && !bus.bus_clk) begin
            st <= H_LATCH;
          end
        end
        H_LATCH: begin
          bus.addr_capture_strobe <= 1'b0;
          bus.data_host_oe <= !rd_op;
          if (is_sync) begin
            bus.wr_dir <= rd_op;
            bus.rd_we_n <= 1'b0;
          end else if (rd_op) begin
            bus.rd_we_n <= 1'b0;
          end else begin
            bus.wr_dir <= 1'b0;
          end
          st <= H_STRB;
        end
        H_STRB: begin
          if (!rdy_s2) begin
            rdata <= bus.data_bus;
            bus.rd_we_n <= 1'b1;
            bus.wr_dir <= 1'b1;
            st <= H_END;
          end
        end
        H_END: begin
          if (rdy_s2) begin
            bus.cs_n <= 1'b1;
            bus.data_host_oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            st <= H_IDLE;
          end
        end
        default: begin
          st <= H_IDLE;
        end
      endcase
    end
  end
endmodule : hpp_host

//--- include/hpp_if.sv
`timescale 1ns/1ps
interface hpp_if;
  import hpp_pkg::*;
  logic [2:0] host_mode_select;
  logic [ADDR_W-1:0] addr;
  logic [CSEL_W-1:0] addr_hi;
  logic cs_n;
  logic addr_capture_strobe;
  logic rd_we_n;
  logic wr_dir;
  logic cycle_done_n;
  logic bus_clk;
  logic [DATA_W-1:0] data_host;
  logic data_host_oe;
  logic [DATA_W-1:0] data_dev;
  logic data_dev_oe;
  logic [DATA_W-1:0] data_bus;
  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : '1);
  modport dev(input host_mode_select, addr, addr_hi, cs_n, addr_capture_strobe, rd_we_n,
              wr_dir, bus_clk, data_bus, output cycle_done_n, data_dev, data_dev_oe);
  modport host(output host_mode_select, addr, addr_hi, cs_n, addr_capture_strobe, rd_we_n,
               wr_dir, bus_clk, data_host, data_host_oe, input cycle_done_n, data_bus);
endinterface : hpp_if

//--- include/hpp_pkg.sv
package hpp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CSEL_W = 3;
  localparam logic [2:0] MODE_STROBE = 3'h0;
  localparam logic [2:0] MODE_DIRLINE = 3'h1;
  localparam logic [2:0] MODE_SYNC = 3'h7;
  localparam int SYS_CLK_NS = 40;
  localparam int STRB_TO_DONE_NS = 150;
  localparam int DONE_CYC = (STRB_TO_DONE_NS / SYS_CLK_NS) < 1 ? 1 :
                            (STRB_TO_DONE_NS / SYS_CLK_NS);
  localparam int HOST_DIV = 2;
  localparam int REG_DEPTH = 256;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] DEV_ID_DEFAULT = 3'h0;
  typedef logic [DATA_W-1:0] hpp_data_t;
  typedef logic [ADDR_W-1:0] hpp_addr_t;
endpackage : hpp_pkg

//--- verification/hpp_chk.sv
`timescale 1ns/1ps
module hpp_chk
  import hpp_pkg::*;
#(
  parameter logic [CSEL_W-1:0] DEV_ID = DEV_ID_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] host_mode_select,
  input wire logic [CSEL_W-1:0] addr_hi,
  input wire logic cs_n,
  input wire logic rd_we_n,
  input wire logic wr_dir,
  input wire logic cycle_done_n,
  input wire logic bus_clk,
  input wire logic data_host_oe,
  input wire logic data_dev_oe
);
  import hpp_pkg::*;
  logic sel;
  logic rd;
  logic act;
  assign sel = !cs_n && addr_hi == DEV_ID;
  assign rd = (host_mode_select == MODE_STROBE) ? !rd_we_n : (!rd_we_n && wr_dir);
  assign act = !rd_we_n || (host_mode_select == MODE_STROBE && !wr_dir);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    sel && $rose(act);
  endsequence
  sequence s_done;
    ##[1:60] !cycle_done_n;
  endsequence
  a_done_latency: assert property (s_req |-> s_done)
    else $error("completion late");
  a_done_release: assert property ($fell(act) |-> ##[1:40] cycle_done_n)
    else $error("completion not released");
  a_done_holds: assert property (sel && act && !cycle_done_n |=> !cycle_done_n)
    else $error("completion dropped early");
  a_done_selected: assert property ($fell(cycle_done_n) |-> sel && act)
    else $error("completion without selection");
  a_oe_read: assert property ($rose(data_dev_oe) |-> sel && rd)
    else $error("data driven outside read");
  a_no_contend: assert property (data_dev_oe |-> !data_host_oe)
    else $error("data bus contention");
  a_idle_quiet: assert property (cs_n [*8] |-> cycle_done_n && !data_dev_oe)
    else $error("activity while deselected");
  a_clk_div: assert property ($changed(bus_clk) |=> $stable(bus_clk) ##1 $changed(bus_clk))
    else $error("bus clock rate wrong");
endmodule : hpp_chk

//--- verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import hpp_pkg::*;
  localparam logic [CSEL_W-1:0] ID = 3'h5;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req = 1'b0;
  logic req_rd = 1'b0;
  logic busy, done;
  logic [2:0] mode = MODE_STROBE;
  logic [2:0] user_mode;
  logic [CSEL_W-1:0] req_dev = ID;
  hpp_addr_t req_addr = 8'h00;
  hpp_addr_t user_addr = 8'h00;
  hpp_data_t req_wdata = 8'h00;
  hpp_data_t rdata, user_rdata;
  int err_count = 0;
  int num_checks = 0;
  hpp_if u_if();
  hpp_dev #(.DEV_ID(ID)) i_hpp_dev (.bus(u_if), .clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(1'b1), .user_addr(user_addr), .user_rdata(user_rdata), .user_mode(user_mode));
  hpp_host i_hpp_host (.bus(u_if), .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
    .mode(mode), .req(req), .req_rd(req_rd), .req_dev(req_dev), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
  hpp_chk #(.DEV_ID(ID)) i_hpp_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .host_mode_select(u_if.host_mode_select), .addr_hi(u_if.addr_hi), .cs_n(u_if.cs_n),
    .rd_we_n(u_if.rd_we_n), .wr_dir(u_if.wr_dir), .cycle_done_n(u_if.cycle_done_n),
    .bus_clk(u_if.bus_clk), .data_host_oe(u_if.data_host_oe), .data_dev_oe(u_if.data_dev_oe));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task results;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task xfer(input logic rd, input hpp_addr_t a, input hpp_data_t wd);
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge clk_sys);
    req <= 1'b1;
    req_rd <= rd;
    req_addr <= a;
    req_wdata <= wd;
    @(posedge clk_sys);
    req <= 1'b0;
    for (n = 0; n < 400 && done !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
      if (u_if.cycle_done_n === 1'b0 && !seen) begin
        seen = 1'b1;
        `CHK(u_if.addr, a)
        `CHK(u_if.addr_hi, ID)
        `CHK(busy, 1'b1)
        if (!rd) `CHK(u_if.data_bus, wd)
      end
    end
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask : xfer
  task peek(input hpp_addr_t a, input hpp_data_t exp);
    @(posedge clk_sys);
    user_addr <= a;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(user_rdata, exp)
  endtask : peek
  task t_modes;
    logic [2:0] m [3];
    m = '{MODE_STROBE, MODE_DIRLINE, MODE_SYNC};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      mode <= m[i];
      repeat (6) @(posedge clk_sys);
      #1;
      `CHK(user_mode, m[i])
      xfer(1'b0, 8'h10 + 8'(i), 8'ha5 ^ 8'(i));
      xfer(1'b1, 8'h10 + 8'(i), 8'h00);
      `CHK(rdata, 8'ha5 ^ 8'(i))
      peek(8'h10 + 8'(i), 8'ha5 ^ 8'(i));
    end
  endtask : t_modes
  task t_edges;
    @(posedge clk_sys);
    mode <= MODE_STROBE;
    repeat (12) @(posedge clk_sys);
    xfer(1'b0, 8'h00, 8'h3c);
    xfer(1'b0, 8'hff, 8'hc3);
    xfer(1'b1, 8'hff, 8'h00);
    `CHK(rdata, 8'hc3)
    xfer(1'b1, 8'h00, 8'h00);
    `CHK(rdata, 8'h3c)
    peek(8'h10, 8'ha5);
  endtask : t_edges
  task t_other_dev;
    int n;
    logic quiet;
    quiet = 1'b1;
    xfer(1'b0, 8'h20, 8'h5a);
    @(posedge clk_sys);
    req_dev <= ID ^ 3'h1;
    req_rd <= 1'b0;
    req_addr <= 8'h20;
    req_wdata <= 8'hff;
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    for (n = 0; n < 80; n++) begin
      @(posedge clk_sys);
      #1;
      if (u_if.cycle_done_n !== 1'b1 || u_if.data_dev_oe !== 1'b0) begin
        quiet = 1'b0;
      end
    end
    `CHK(quiet, 1'b1)
    `CHK(busy, 1'b1)
    @(posedge clk_sys);
    rst_b <= 1'b0;
    req_dev <= ID;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(u_if.cs_n, 1'b1)
    `CHK(busy, 1'b0)
    xfer(1'b1, 8'h20, 8'h00);
    `CHK(rdata, 8'h5a)
  endtask : t_other_dev
  initial begin
    #(40 * 20000);
    err_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_modes();
    t_edges();
    t_other_dev();
    results();
  end
endmodule : tb
